// ==== trig_out_pkg.sv ====
/*
  Shared constants and types for the alert-triggered output update block:
  register offsets, reset values, the register request carrier and the
  packed state record.
  Assumes an 8-bit register port and eight input channels and eight outputs.
*/
package trig_out_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH  = 8;
  localparam int NUM_OUT = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OUT0_SEL_ADDR   = 8'hC3;  // output 0 select
  localparam logic [7:0] SEL_STRIDE      = 8'h02;  // select regs are 2 apart
  localparam logic [7:0] OUT6_SEL_ADDR   = 8'hCF;
  localparam logic [7:0] OUT7_SEL_ADDR   = 8'hD1;
  localparam logic [7:0] UPD_EN_ADDR     = 8'hE9;
  localparam logic [7:0] LVL_ADDR        = 8'hEB;
  localparam logic [7:0] PIN_STAT_ADDR   = 8'hF0;  // read only
  localparam logic [7:0] TRIG_SEEN_ADDR  = 8'hF2;  // write 1 to clear

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_RESET       = 8'h00;
  localparam logic [7:0] UPD_EN_RESET    = 8'h00;
  localparam logic [7:0] LVL_RESET       = 8'h00;
  localparam logic [7:0] PIN_RESET       = 8'h00;
  localparam logic [7:0] SEEN_RESET      = 8'h00;
  localparam logic [7:0] RDATA_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_OUT-1:0][NUM_CH-1:0] sel;      // per-output channel select
    logic [NUM_OUT-1:0]             upd_en;   // trigger update enable
    logic [NUM_OUT-1:0]             lvl;      // level on trigger
    logic [NUM_CH-1:0]              flags_q;  // previous alert flags
    logic [NUM_OUT-1:0]             pins;     // output levels
    logic [NUM_OUT-1:0]             seen;     // sticky trigger seen
    logic [7:0]                     rdata;    // read data
  } state_t;

  localparam state_t STATE_RESET = '{
    sel:     {NUM_OUT{SEL_RESET}},
    upd_en:  UPD_EN_RESET,
    lvl:     LVL_RESET,
    flags_q: 8'h00,
    pins:    PIN_RESET,
    seen:    SEEN_RESET,
    rdata:   RDATA_RESET
  };

endpackage : trig_out_pkg

// ==== alert_triggered_output_update.sv ====
/*
  Alert-triggered update of the eight digital outputs: per-output channel
  select, per-output update enable and per-output level on trigger, all
  reached over a plain register port with read data one cycle later.
  Assumes alert flags come from logic on ref_clk, so they are not
  synchronised; pin electrical setup lives elsewhere.
*/
`timescale 1ns/1ps

module alert_triggered_output_update
  import trig_out_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire reg_req_t           reg_req,
  input  wire logic [NUM_CH-1:0]  alert_flags,
  output logic      [7:0]         rd_data,
  output logic      [NUM_OUT-1:0] digital_output_pin,
  output logic      [NUM_OUT-1:0] trigger_seen
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_t             s_q;
  state_t             s_d;
  logic [NUM_CH-1:0]  rise;
  logic [NUM_OUT-1:0] fire;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // edge detect, trigger, register writes and read mux
  always_comb begin
    s_d         = s_q;
    s_d.flags_q = alert_flags;
    rise        = alert_flags & ~s_q.flags_q;

    // per-output trigger from selected rising flags
    for (int k = 0; k < NUM_OUT; k++) begin
      fire[k] = |(rise & s_q.sel[k]);
    end

    // drive level only on enabled outputs
    for (int k = 0; k < NUM_OUT; k++) begin
      if (fire[k] && s_q.upd_en[k]) begin
        s_d.pins[k] = s_q.lvl[k];
      end
    end

    // register writes
    if (reg_req.wr) begin
      for (int k = 0; k < NUM_OUT; k++) begin
        if (reg_req.addr == 8'(OUT0_SEL_ADDR + SEL_STRIDE * 8'(k))) begin
          s_d.sel[k] = reg_req.wdata;
        end
      end
      case (reg_req.addr)
        UPD_EN_ADDR: begin
          s_d.upd_en = reg_req.wdata;
        end
        LVL_ADDR: begin
          s_d.lvl = reg_req.wdata;
        end
        TRIG_SEEN_ADDR: begin
          s_d.seen = s_q.seen & ~reg_req.wdata;  // write 1 clears
        end
        default: begin
        end
      endcase
    end

    // a new trigger wins over a clear in the same cycle
    s_d.seen = s_d.seen | (fire & s_q.upd_en);

    // read data stands for one cycle after the strobe
    s_d.rdata = 8'h00;
    if (reg_req.rd) begin
      for (int k = 0; k < NUM_OUT; k++) begin
        if (reg_req.addr == 8'(OUT0_SEL_ADDR + SEL_STRIDE * 8'(k))) begin
          s_d.rdata = s_q.sel[k];
        end
      end
      case (reg_req.addr)
        UPD_EN_ADDR: begin
          s_d.rdata = s_q.upd_en;
        end
        LVL_ADDR: begin
          s_d.rdata = s_q.lvl;
        end
        PIN_STAT_ADDR: begin
          s_d.rdata = s_q.pins;
        end
        TRIG_SEEN_ADDR: begin
          s_d.rdata = s_q.seen;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all state in one record
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rd_data            = s_q.rdata;
  assign digital_output_pin = s_q.pins;
  assign trigger_seen       = s_q.seen;

endmodule : alert_triggered_output_update

// ==== out_load.sv ====
/* load on the digital output pins: senses the driven levels.
   assumes push-pull pins, always driven. */
`timescale 1ns/1ps
module out_load (
  input  wire logic [7:0] pin_level,
  output logic      [7:0] sensed
);
  // pins are always driven, so the load sees them as they are
  assign sensed = pin_level;
endmodule : out_load

// ==== trig_out_chk.sv ====
/* port checker for the alert-triggered output block.
   assumes it sees only the top module's ports; bound below. */
`timescale 1ns/1ps
module trig_out_chk
  import trig_out_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      rst_n,
  input wire reg_req_t  reg_req,
  input wire logic [7:0] alert_flags,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] digital_output_pin,
  input wire logic [7:0] trigger_seen
);
  logic [7:0] fl_q, en_q, lv_q, s6_q, s7_q, rise;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // mirror of the enable, level and output 6 and 7 select registers and of last flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) {fl_q, en_q, lv_q, s6_q, s7_q} <= '0;
    else begin
      fl_q <= alert_flags;
      if (reg_req.wr && reg_req.addr == UPD_EN_ADDR) en_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == LVL_ADDR) lv_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == OUT6_SEL_ADDR) s6_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == OUT7_SEL_ADDR) s7_q <= reg_req.wdata;
    end
  end
  assign rise = alert_flags & ~fl_q;
  rd_idle_a: assert property (!$past(reg_req.rd) |-> rd_data == 8'h00) else $error("rd idle");
  en_rd_a: assert property (reg_req.rd && reg_req.addr == UPD_EN_ADDR |=> rd_data == $past(en_q))
    else $error("enable read");
  lv_rd_a: assert property (reg_req.rd && reg_req.addr == LVL_ADDR |=> rd_data == $past(lv_q))
    else $error("level read");
  dis_hold_a: assert property (((digital_output_pin ^ $past(digital_output_pin)) & ~$past(en_q)) == 8'h00)
    else $error("disabled pin moved");
  lvl_ok_a: assert property (((digital_output_pin ^ $past(digital_output_pin))
    & (digital_output_pin ^ $past(lv_q))) == 8'h00) else $error("wrong level");
  trig6_a: assert property (en_q[6] && |(rise & s6_q) |=> digital_output_pin[6] == $past(lv_q[6]) && trigger_seen[6])
    else $error("out6 trigger");
  trig7_a: assert property (en_q[7] && |(rise & s7_q) |=> digital_output_pin[7] == $past(lv_q[7]) && trigger_seen[7])
    else $error("out7 trigger");
  skip6_a: assert property (!(|(rise & s6_q)) |=> $stable(digital_output_pin[6])) else $error("out6 moved");
  cover property (en_q[6] && |(rise & s6_q));
  cover property (en_q[7] && |(rise & s7_q));
  cover property (!en_q[6] && |(rise & s6_q));
endmodule : trig_out_chk
bind alert_triggered_output_update trig_out_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
  .alert_flags(alert_flags), .rd_data(rd_data), .digital_output_pin(digital_output_pin), .trigger_seen(trigger_seen));

// ==== tb_alert_triggered_output_update.sv ====
/* testbench for the alert-triggered output block.
   assumes the package, the load model and the bound checker. */
`timescale 1ns/1ps
module tb_alert_triggered_output_update
  import trig_out_pkg::*;
;
  logic     ref_clk = 1'b0;
  logic     rst_n   = 1'b0;
  reg_req_t rq      = '0;
  logic [7:0] flags = 8'h00;
  logic [7:0] rdd, pin, seen, lv;
  int err_count   = 0;
  int checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  alert_triggered_output_update dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(rq), .alert_flags(flags),
    .rd_data(rdd), .digital_output_pin(pin), .trigger_seen(seen));
  out_load load (.pin_level(pin), .sensed(lv));
  task chk(string n, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk) rq <= '{1'b0, 1'b1, a, d};
    @(posedge ref_clk) rq <= '0;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk) rq <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge ref_clk) rq <= '0;
    #1 chk("read", rdd, e);
  endtask : rd
  // one-cycle flag pulse, then let the pin settle
  task pulse(logic [7:0] m);
    @(posedge ref_clk) flags <= m;
    @(posedge ref_clk) flags <= 8'h00;
    @(posedge ref_clk);
    #1;
  endtask : pulse
  task t_reset();
    rd(OUT6_SEL_ADDR, 8'h00);
    rd(OUT7_SEL_ADDR, 8'h00);
    rd(UPD_EN_ADDR, 8'h00);
    rd(LVL_ADDR, 8'h00);
    rd(8'h00, 8'h00);
  endtask : t_reset
  task t_trig();
    wr(OUT6_SEL_ADDR, 8'h01);
    wr(OUT7_SEL_ADDR, 8'h04);
    wr(LVL_ADDR, 8'h40);
    wr(UPD_EN_ADDR, 8'hC0);
    rd(UPD_EN_ADDR, 8'hC0);
    pulse(8'h02);
    chk("pin", pin, 8'h00);
    pulse(8'h01);
    chk("pin", pin, 8'h40);
    pulse(8'h04);
    chk("seen", seen, 8'hC0);
    chk("load", lv, 8'h40);
  endtask : t_trig
  task t_dis();
    wr(LVL_ADDR, 8'hBF);
    rd(LVL_ADDR, 8'hBF);
    wr(UPD_EN_ADDR, 8'h80);
    pulse(8'h05);
    chk("pin", pin, 8'hC0);
    wr(UPD_EN_ADDR, 8'h40);
    pulse(8'h01);
    chk("pin", pin, 8'h80);
  endtask : t_dis
  // pin status read, seen clear, read-only write, and set beating clear
  task t_seen();
    rd(PIN_STAT_ADDR, 8'h80);
    wr(TRIG_SEEN_ADDR, 8'h80);
    rd(TRIG_SEEN_ADDR, 8'h40);
    wr(PIN_STAT_ADDR, 8'hFF);
    rd(PIN_STAT_ADDR, 8'h80);
    @(posedge ref_clk);
    flags <= 8'h01;
    rq    <= '{1'b0, 1'b1, TRIG_SEEN_ADDR, 8'h40};
    @(posedge ref_clk);
    flags <= 8'h00;
    rq    <= '0;
    @(posedge ref_clk);
    #1 chk("seen", seen, 8'h40);
    chk("pin", pin, 8'h80);
  endtask : t_seen
  task wrap_up();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_trig();
    t_dis();
    t_seen();
    wrap_up();
  end
  // watchdog well past the run length
  initial begin
    #20us;
    err_count++;
    wrap_up();
  end
endmodule : tb_alert_triggered_output_update
